//--- pkg/sadc_pkg.sv
package sadc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_CTRL_MAIN  = 4'h0;
	localparam logic [3:0] ADDR_PIN_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_RESULT     = 4'h2;
	localparam logic [3:0] ADDR_FLAG       = 4'h3;
	localparam logic [3:0] ADDR_ENABLE     = 4'h4;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CLK_SEL_LSB = 6;
	localparam int CHAN_LSB    = 3;
	localparam int GO_BIT      = 2;
	localparam int ON_BIT      = 0;
	localparam int DONE_BIT    = 6;
	localparam int IRQ_EN_BIT  = 6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0] CLK_SEL_RST = 2'h0;
	localparam logic [2:0] CHAN_RST    = 3'h0;
	localparam logic [2:0] PORT_ANALOG_CONFIG_RST    = 3'h0;
	localparam logic [7:0] RESULT_RST  = 8'h00;

	// ****************************************
	// Clock sources
	// ****************************************
	localparam logic [1:0] CLK_SEL_DIV2  = 2'h0;
	localparam logic [1:0] CLK_SEL_DIV8  = 2'h1;
	localparam logic [1:0] CLK_SEL_DIV32 = 2'h2;
	localparam logic [1:0] CLK_SEL_RC    = 2'h3;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS       = 10;
	localparam int RC_START_DELAY_NS   = 40;
	localparam int RC_START_DELAY_CLKS =
		(RC_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] HALF_DIV2   = 5'h01;
	localparam logic [4:0] HALF_DIV8   = 5'h04;
	localparam logic [4:0] HALF_DIV32  = 5'h10;
	localparam logic [4:0] CONV_HALF_TADS   = 5'h13;
	localparam logic [4:0] FIRST_DECISION   = 5'h05;
	localparam logic [2:0] ABORT_HALF_TADS  = 3'h4;

	typedef enum logic [1:0] {
		SADC_ACQUIRE   = 2'b00,
		SADC_START_DLY = 2'b01,
		SADC_CONVERT   = 2'b10,
		SADC_ABORT     = 2'b11
	} sadc_state_t;

endpackage

//--- pkg/sadc_sar_if.sv
interface sadc_sar_if;
	logic       start;
	logic       abort;
	logic       half_tick;
	logic       comp;
	logic       busy;
	logic       done;
	logic [7:0] result;
	logic [7:0] trial;

	modport ctl (
		output start,
		output abort,
		output half_tick,
		output comp,
		input  busy,
		input  done,
		input  result,
		input  trial
	);

	modport core (
		input  start,
		input  abort,
		input  half_tick,
		input  comp,
		output busy,
		output done,
		output result,
		output trial
	);
endinterface

//--- logic/sadc_sar_core.sv
module sadc_sar_core (
	input wire logic clk,
	input wire logic rstn,
	sadc_sar_if.core sar
);

	// ****************************************
	// Approximation register
	// ****************************************
	logic       busy;
	logic [4:0] half_count;
	logic [7:0] trial;
	logic [7:0] mask;
	logic [7:0] result;
	logic       done;
	logic       next_busy;
	logic [4:0] next_half_count;
	logic [7:0] next_trial;
	logic [7:0] next_mask;
	logic [7:0] next_result;
	logic       next_done;

	always_comb begin
		logic [4:0] cnt;
		logic [7:0] kept;
		cnt = half_count + 5'h01;
		kept = sar.comp ? trial : (trial & ~mask);
		next_busy = busy;
		next_half_count = half_count;
		next_trial = trial;
		next_mask = mask;
		next_result = result;
		next_done = 1'b0;
		if (sar.abort) begin
			next_busy = 1'b0;
		end else if (sar.start) begin
			next_busy = 1'b1;
			next_half_count = 5'h00;
			next_trial = 8'h80;
			next_mask = 8'h80;
		end else if (busy && sar.half_tick) begin
			next_half_count = cnt;
			// Setup takes 1.5 periods, then one decision per period
			if (cnt >= sadc_pkg::FIRST_DECISION && cnt[0]) begin
				next_mask = mask >> 1;
				next_trial = kept | (mask >> 1);
			end
			if (cnt == sadc_pkg::CONV_HALF_TADS) begin
				next_busy = 1'b0;
				next_result = kept;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			busy <= 1'b0;
			half_count <= 5'h00;
			trial <= 8'h00;
			mask <= 8'h00;
			result <= sadc_pkg::RESULT_RST;
			done <= 1'b0;
		end else begin
			busy <= next_busy;
			half_count <= next_half_count;
			trial <= next_trial;
			mask <= next_mask;
			result <= next_result;
			done <= next_done;
		end
	end

	assign sar.busy = busy;
	assign sar.done = done;
	assign sar.result = result;
	assign sar.trial = trial;

endmodule // sadc_sar_core

//--- logic/sadc_top.sv
// Function
// - Eight-bit successive approximation result stored
// - Channel field routes input to sample-hold
// - Clock select: /2, /8, /32, RC
// - Conversion lasts nine and half periods
// - Port config picks supply or external reference
// - Done flag set after every conversion
// - Only software write clears done flag
// - Enabled interrupt wakes sleeping core on completion
// - Converter on enables; go starts conversion
// - Finish clears go, sets flag, loads result
// - Clearing go aborts, keeps old result
// - After abort wait two periods, reacquire
// - Reset restores registers, converter off
// - RC clock delays start one instruction
// - Sleep, RC, no interrupt: power down after
// - Sleep with other clock aborts, powers down
// - Trigger sets go, resets time base
// - Codes 0-3 route inputs; others reserved
// - Go reads one while converting
//
// Chosen here: the address-and-strobe port and the placing of the registers.
module sadc_top (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       sleep_mode,
	input  wire logic       special_event_trigger,
	input  wire logic       rc_clock_pin,
	input  wire logic       comparator_pin,
	output logic      [1:0] analog_channel,
	output logic            channel_valid,
	output logic            sample_hold_en,
	output logic            vref_external,
	output logic            converter_powered,
	output logic      [7:0] trial_code,
	output logic            wake_request,
	output logic            time_base_reset
);

	sadc_sar_if sar ();

	sadc_sar_core u_core (
		.clk  (clk),
		.rstn (rstn),
		.sar  (sar)
	);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [4:0] half_period(input logic [1:0] sel);
		logic [4:0] h;
		h = sadc_pkg::HALF_DIV32;
		if (sel == sadc_pkg::CLK_SEL_DIV2) begin
			h = sadc_pkg::HALF_DIV2;
		end else if (sel == sadc_pkg::CLK_SEL_DIV8) begin
			h = sadc_pkg::HALF_DIV8;
		end
		return h;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic rc_s1;
	logic rc_s2;
	logic rc_s3;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rc_s1 <= 1'b0;
			rc_s2 <= 1'b0;
			rc_s3 <= 1'b0;
		end else begin
			rc_s1 <= rc_clock_pin;
			rc_s2 <= rc_s1;
			rc_s3 <= rc_s2;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [1:0] clk_sel;
	logic [2:0] chan_sel;
	logic       go;
	logic       converter_on;
	logic [2:0] port_analog_config;
	logic [7:0] result;
	logic       done_flag;
	logic       irq_en;
	logic       power_down;
	logic       sleep_prev;
	logic [7:0] rd_q;
	logic       trig_q;
	logic [1:0] next_clk_sel;
	logic [2:0] next_chan_sel;
	logic       next_go;
	logic       next_converter_on;
	logic [2:0] next_port_analog_config;
	logic [7:0] next_result;
	logic       next_done_flag;
	logic       next_irq_en;
	logic       next_power_down;
	logic [7:0] next_rd_q;
	logic       next_trig_q;
	logic       rc_selected;
	logic       sleep_entry;

	assign rc_selected = (clk_sel == sadc_pkg::CLK_SEL_RC);
	assign sleep_entry = sleep_mode && !sleep_prev;

	always_comb begin
		next_clk_sel = clk_sel;
		next_chan_sel = chan_sel;
		next_go = go;
		next_converter_on = converter_on;
		next_port_analog_config = port_analog_config;
		next_result = result;
		next_done_flag = done_flag;
		next_irq_en = irq_en;
		next_power_down = power_down;
		next_rd_q = 8'h00;
		next_trig_q = 1'b0;
		if (wr_en && addr == sadc_pkg::ADDR_CTRL_MAIN) begin
			next_clk_sel = wdata[sadc_pkg::CLK_SEL_LSB +: 2];
			next_chan_sel = wdata[sadc_pkg::CHAN_LSB +: 3];
			next_converter_on = wdata[sadc_pkg::ON_BIT];
			// Go from the same write that turns the converter on is dropped
			if (converter_on) begin
				next_go = wdata[sadc_pkg::GO_BIT];
			end
		end else if (wr_en && addr == sadc_pkg::ADDR_PIN_CONFIG) begin
			next_port_analog_config = wdata[2:0];
		end else if (wr_en && addr == sadc_pkg::ADDR_FLAG) begin
			next_done_flag = wdata[sadc_pkg::DONE_BIT];
		end else if (wr_en && addr == sadc_pkg::ADDR_ENABLE) begin
			next_irq_en = wdata[sadc_pkg::IRQ_EN_BIT];
		end
		if (special_event_trigger && converter_on) begin
			next_go = 1'b1;
			next_trig_q = 1'b1;
		end
		if (sleep_entry && !rc_selected) begin
			next_go = 1'b0;
			next_power_down = 1'b1;
		end
		if (sar.done) begin
			next_go = 1'b0;
			next_done_flag = 1'b1;
			next_result = sar.result;
		end
		if (sar.done && sleep_mode && rc_selected && !irq_en) begin
			next_power_down = 1'b1;
		end
		if (!sleep_mode || !converter_on) begin
			next_power_down = 1'b0;
		end
		if (!converter_on || !next_converter_on) begin
			next_go = 1'b0;
		end
		if (rd_en) begin
			if (addr == sadc_pkg::ADDR_CTRL_MAIN) begin
				next_rd_q = {clk_sel, chan_sel, go, 1'b0, converter_on};
			end else if (addr == sadc_pkg::ADDR_PIN_CONFIG) begin
				next_rd_q = {5'h00, port_analog_config};
			end else if (addr == sadc_pkg::ADDR_RESULT) begin
				next_rd_q = result;
			end else if (addr == sadc_pkg::ADDR_FLAG) begin
				next_rd_q = {1'b0, done_flag, 6'h00};
			end else if (addr == sadc_pkg::ADDR_ENABLE) begin
				next_rd_q = {1'b0, irq_en, 6'h00};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			clk_sel <= sadc_pkg::CLK_SEL_RST;
			chan_sel <= sadc_pkg::CHAN_RST;
			go <= 1'b0;
			converter_on <= 1'b0;
			port_analog_config <= sadc_pkg::PORT_ANALOG_CONFIG_RST;
			result <= sadc_pkg::RESULT_RST;
			done_flag <= 1'b0;
			irq_en <= 1'b0;
			power_down <= 1'b0;
			sleep_prev <= 1'b0;
			rd_q <= 8'h00;
			trig_q <= 1'b0;
		end else begin
			clk_sel <= next_clk_sel;
			chan_sel <= next_chan_sel;
			go <= next_go;
			converter_on <= next_converter_on;
			port_analog_config <= next_port_analog_config;
			result <= next_result;
			done_flag <= next_done_flag;
			irq_en <= next_irq_en;
			power_down <= next_power_down;
			sleep_prev <= sleep_mode;
			rd_q <= next_rd_q;
			trig_q <= next_trig_q;
		end
	end

	// ****************************************
	// Half-period tick
	// ****************************************
	logic       powered;
	logic [4:0] div_count;
	logic [4:0] next_div_count;
	logic       half_tick;
	logic       start_pulse;
	logic       abort_pulse;

	assign powered = converter_on && !power_down;

	always_comb begin
		logic [4:0] last;
		last = half_period(clk_sel) - 5'h01;
		next_div_count = 5'h00;
		half_tick = 1'b0;
		if (powered && rc_selected) begin
			half_tick = rc_s2 ^ rc_s3;
		end else if (powered) begin
			half_tick = (div_count >= last);
			next_div_count = half_tick ? 5'h00 : div_count + 5'h01;
		end
		if (start_pulse || abort_pulse) begin
			next_div_count = 5'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			div_count <= 5'h00;
		end else begin
			div_count <= next_div_count;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	sadc_pkg::sadc_state_t state;
	sadc_pkg::sadc_state_t next_state;
	logic [2:0] seq_count;
	logic [2:0] next_seq_count;

	always_comb begin
		next_state = state;
		next_seq_count = seq_count;
		start_pulse = 1'b0;
		abort_pulse = 1'b0;
		case (state)
			sadc_pkg::SADC_ACQUIRE: begin
				if (go && rc_selected) begin
					next_state = sadc_pkg::SADC_START_DLY;
					next_seq_count = 3'h0;
				end else if (go) begin
					next_state = sadc_pkg::SADC_CONVERT;
					start_pulse = 1'b1;
				end
			end
			sadc_pkg::SADC_START_DLY: begin
				if (!go) begin
					next_state = sadc_pkg::SADC_ABORT;
					next_seq_count = 3'h0;
				end else if (seq_count == 3'(sadc_pkg::RC_START_DELAY_CLKS - 1)) begin
					next_state = sadc_pkg::SADC_CONVERT;
					start_pulse = 1'b1;
				end else begin
					next_seq_count = seq_count + 3'h1;
				end
			end
			sadc_pkg::SADC_CONVERT: begin
				if (sar.done) begin
					next_state = sadc_pkg::SADC_ACQUIRE;
				end else if (!go) begin
					next_state = sadc_pkg::SADC_ABORT;
					next_seq_count = 3'h0;
					abort_pulse = 1'b1;
				end
			end
			sadc_pkg::SADC_ABORT: begin
				if (half_tick && seq_count == sadc_pkg::ABORT_HALF_TADS - 3'h1) begin
					next_state = sadc_pkg::SADC_ACQUIRE;
				end else if (half_tick) begin
					next_seq_count = seq_count + 3'h1;
				end
			end
			default: begin
				next_state = sadc_pkg::SADC_ACQUIRE;
			end
		endcase
		// Power loss ends everything at once; no abort wait is owed
		if (!powered) begin
			next_state = sadc_pkg::SADC_ACQUIRE;
			start_pulse = 1'b0;
			abort_pulse = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= sadc_pkg::SADC_ACQUIRE;
			seq_count <= 3'h0;
		end else begin
			state <= next_state;
			seq_count <= next_seq_count;
		end
	end

	assign sar.start = start_pulse;
	assign sar.abort = abort_pulse;
	assign sar.half_tick = half_tick;
	assign sar.comp = comparator_pin; // Same-clock answer to trial code; resync lag breaks /2

	// ****************************************
	// Outputs
	// ****************************************
	assign rdata = rd_q;
	assign analog_channel = chan_sel[1:0];
	assign channel_valid = !chan_sel[2];
	assign sample_hold_en = powered && !chan_sel[2] && state == sadc_pkg::SADC_ACQUIRE;
	assign vref_external = port_analog_config[0] && !(port_analog_config[2] && port_analog_config[1]);
	assign converter_powered = powered;
	assign trial_code = sar.trial;
	assign wake_request = done_flag && irq_en && sleep_mode;
	assign time_base_reset = trig_q;

endmodule // sadc_top

//--- bench/sadc_analog_model.sv
// ****************************************
// Analog inputs and comparator
// ****************************************
module sadc_analog_model #(
	parameter logic [31:0] LEVELS = 32'h00FF3CA5
) (
	input  wire logic [1:0] analog_channel,
	input  wire logic [7:0] trial_code,
	output logic            comparator_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ideal source, so the settle wait is only to keep the order
	assign comparator_pin = LEVELS[{analog_channel, 3'b000} +: 8] >= trial_code;
endmodule // sadc_analog_model

//--- bench/sadc_assertions.sv
// ****************************************
// Port checker
// ****************************************
module sadc_assertions (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic [7:0] rdata,
	input wire logic       sleep_mode,
	input wire logic       special_event_trigger,
	input wire logic [1:0] analog_channel,
	input wire logic       channel_valid,
	input wire logic       sample_hold_en,
	input wire logic       vref_external,
	input wire logic       converter_powered,
	input wire logic       wake_request,
	input wire logic       time_base_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl;
	logic [2:0] cfg;
	logic       irq;

	// Shadow copies, go bit not tracked
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctl <= 8'h00;
			cfg <= 3'h0;
			irq <= 1'b0;
		end else if (wr_en) begin
			if (addr == sadc_pkg::ADDR_CTRL_MAIN) ctl <= wdata;
			if (addr == sadc_pkg::ADDR_PIN_CONFIG) cfg <= wdata[2:0];
			if (addr == sadc_pkg::ADDR_ENABLE) irq <= wdata[6];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	reset_state_a: assert property ($rose(rstn) |-> rdata == 8'h00 && channel_valid
		&& !converter_powered && !wake_request && !time_base_reset) else $error("reset state");
	chan_route_a: assert property (analog_channel == ctl[4:3]
		&& channel_valid == !ctl[5]) else $error("channel routing");
	vref_pick_a: assert property (vref_external == (cfg[0] && cfg[2:1] != 2'h3))
		else $error("reference select");
	off_unpowered_a: assert property (!ctl[0] |-> !converter_powered)
		else $error("powered while off");
	sh_gated_a: assert property (sample_hold_en |-> channel_valid && converter_powered)
		else $error("sample gate");
	wake_cause_a: assert property (wake_request |-> sleep_mode && irq)
		else $error("wake cause");
	tbr_accept_a: assert property (special_event_trigger && sample_hold_en
		|=> time_base_reset ##1 !time_base_reset) else $error("trigger pulse");
	tbr_cause_a: assert property (time_base_reset |-> $past(special_event_trigger && ctl[0]))
		else $error("stray timer reset");
	sleep_down_a: assert property (sleep_mode && $past(sleep_mode)
		&& ctl[7:6] != sadc_pkg::CLK_SEL_RC |-> !converter_powered) else $error("sleep power");

	cover property (time_base_reset);
	cover property ($rose(wake_request));
	cover property (sleep_mode && ctl[0] && !converter_powered);
endmodule // sadc_assertions

bind sadc_top sadc_assertions u_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rdata(rdata), .sleep_mode(sleep_mode),
	.special_event_trigger(special_event_trigger), .analog_channel(analog_channel),
	.channel_valid(channel_valid), .sample_hold_en(sample_hold_en),
	.vref_external(vref_external), .converter_powered(converter_powered),
	.wake_request(wake_request), .time_base_reset(time_base_reset));

//--- bench/tb_top.sv
// ****************************************
// Testbench
// ****************************************
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] LV = 32'h00FF3CA5;
	localparam logic [3:0] A_CTL = sadc_pkg::ADDR_CTRL_MAIN;
	localparam logic [3:0] A_RES = sadc_pkg::ADDR_RESULT;
	localparam logic [3:0] A_FLG = sadc_pkg::ADDR_FLAG;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [7:0] rdata;
	logic       sleep_mode = 1'b0;
	logic       special_event_trigger = 1'b0;
	logic       rc_clock_pin = 1'b0;
	logic       comparator_pin;
	logic [1:0] analog_channel;
	logic       channel_valid;
	logic       sample_hold_en;
	logic       vref_external;
	logic       converter_powered;
	logic [7:0] trial_code;
	logic       wake_request;
	logic       time_base_reset;
	logic [7:0] v;
	int         miscompares = 0;
	int         n_compared = 0;
	int         n;

	sadc_top uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .sleep_mode(sleep_mode),
		.special_event_trigger(special_event_trigger), .rc_clock_pin(rc_clock_pin),
		.comparator_pin(comparator_pin), .analog_channel(analog_channel),
		.channel_valid(channel_valid), .sample_hold_en(sample_hold_en),
		.vref_external(vref_external), .converter_powered(converter_powered),
		.trial_code(trial_code), .wake_request(wake_request),
		.time_base_reset(time_base_reset));
	sadc_analog_model #(.LEVELS(LV)) u_ana (.analog_channel(analog_channel),
		.trial_code(trial_code), .comparator_pin(comparator_pin));

	initial begin
		forever #5 clk = ~clk;
	end
	// Free-running oscillator, phase unrelated to clk
	initial begin
		forever #23.7 rc_clock_pin = ~rc_clock_pin;
	end

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic wait_go_low();
		for (int i = 0; i < 400; i++) begin
			rd(A_CTL);
			if (v[2] === 1'b0) return;
		end
		miscompares++;
		end_of_test();
	endtask

	// Counts cycles with sample-hold off, bounded
	task automatic off_len();
		n = 0;
		for (int i = 0; i < 700; i++) begin
			@(posedge clk);
			#1;
			if (sample_hold_en === 1'b0) n++;
			else if (n > 0) return;
		end
		miscompares++;
		end_of_test();
	endtask

	task automatic t_conv(input logic [1:0] ch, input logic [1:0] sel);
		logic [7:0] c;
		int h;
		c = {sel, 1'b0, ch, 3'b001};
		h = (sel == 2'h0) ? 1 : (sel == 2'h1) ? 4 : 16;
		wr(A_CTL, c);
		repeat (20) @(posedge clk);
		wr(A_CTL, c | 8'h04);
		off_len();
		if (sel != sadc_pkg::CLK_SEL_RC) chk(8'(n >= 19 * h - 1 && n <= 19 * h + 3), 8'h01);
		wait_go_low();
		rd(A_RES);
		chk(v, LV[ch * 8 +: 8]);
		rd(A_CTL);
		chk(v, c);
		repeat (10) @(posedge clk);
		rd(A_FLG);
		chk(v, 8'h40);
		wr(A_FLG, 8'h00);
		rd(A_FLG);
		chk(v, 8'h00);
		$display("conversion ch %0d sel %0d done", ch, sel);
	endtask

	task automatic t_trig_abort();
		wr(A_CTL, 8'h00);
		wr(A_CTL, 8'h04);
		@(posedge clk);
		special_event_trigger <= 1'b1;
		@(posedge clk);
		special_event_trigger <= 1'b0;
		rd(A_CTL);
		chk(v, 8'h00);
		wr(A_CTL, 8'h09);
		repeat (20) @(posedge clk);
		special_event_trigger <= 1'b1;
		@(posedge clk);
		special_event_trigger <= 1'b0;
		#1 chk({7'h0, time_base_reset}, 8'h01);
		rd(A_CTL);
		chk(v, 8'h0D);
		wait_go_low();
		wr(A_FLG, 8'h00);
		wr(A_CTL, 8'h81);
		repeat (20) @(posedge clk);
		wr(A_CTL, 8'h85);
		repeat (40) @(posedge clk);
		wr(A_CTL, 8'h81);
		off_len();
		chk(8'(n >= 62 && n <= 68), 8'h01);
		rd(A_RES);
		chk(v, LV[15:8]);
		rd(A_FLG);
		chk(v, 8'h00);
		$display("trigger and abort done");
	endtask

	task automatic t_sleep(input logic [7:0] c, input logic irq);
		wr(sadc_pkg::ADDR_ENABLE, {1'b0, irq, 6'h00});
		wr(A_CTL, c);
		repeat (20) @(posedge clk);
		wr(A_CTL, c | 8'h04);
		@(posedge clk);
		sleep_mode <= 1'b1;
		if (c[7:6] == sadc_pkg::CLK_SEL_RC) begin
			wait_go_low();
			chk({7'h0, wake_request}, {7'h0, irq});
			chk({7'h0, converter_powered}, {7'h0, irq});
		end else begin
			repeat (10) @(posedge clk);
			chk({7'h0, converter_powered}, 8'h00);
		end
		@(posedge clk);
		sleep_mode <= 1'b0;
		rd(A_CTL);
		chk(v, c);
		wr(A_FLG, 8'h00);
		$display("sleep case done");
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		foreach (v[i]) if (i < 6) begin
			rd((i == 5) ? 4'hF : 4'(i));
			chk(v, 8'h00);
		end
		wr(4'hF, 8'hFF);
		rd(4'hF);
		chk(v, 8'h00);
		wr(sadc_pkg::ADDR_PIN_CONFIG, 8'h05);
		rd(sadc_pkg::ADDR_PIN_CONFIG);
		chk(v, 8'h05);
		wr(A_CTL, 8'h21);
		#1 chk({6'h00, channel_valid, sample_hold_en}, 8'h00);
		for (int ch = 0; ch < 4; ch++) t_conv(2'(ch), 2'(ch % 3));
		t_conv(2'h2, sadc_pkg::CLK_SEL_RC);
		t_trig_abort();
		t_sleep(8'hC1, 1'b1);
		t_sleep(8'hC1, 1'b0);
		t_sleep(8'h41, 1'b0);
		rd(A_RES);
		chk(v, LV[7:0]);
		wr(A_CTL, 8'h85);
		repeat (20) @(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(A_CTL);
		chk(v, 8'h00);
		rd(A_RES);
		chk(v, sadc_pkg::RESULT_RST);
		end_of_test();
	end
endmodule // tb_top
